//--- include/jid_pkg.sv
package jid_pkg;

    // instruction register
    localparam int        IR_W          = 4;
    localparam logic [3:0] IR_EXTEST    = 4'h0;
    localparam logic [3:0] IR_SAMPLE    = 4'h1;
    localparam logic [3:0] IR_IDCODE    = 4'h2;
    localparam logic [3:0] IR_HIGHZ     = 4'h4;
    localparam logic [3:0] IR_BYPASS    = 4'hf;
    localparam logic [3:0] IR_CAPTURE   = 4'h1;
    localparam logic [3:0] IR_RESET     = IR_IDCODE;

    // identification fields; values are arbitrary
    localparam int          ID_W        = 32;
    localparam logic [3:0]  ID_VERSION  = 4'h0;
    localparam logic [15:0] ID_PART     = 16'h0a5c;
    localparam logic [10:0] ID_MANUF    = 11'h2d6;
    localparam logic [31:0] ID_VALUE    = {ID_VERSION, ID_PART, ID_MANUF, 1'b1};

    // boundary scan layout: inputs low, outputs high
    localparam int          FIN_W       = 4;
    localparam int          FOUT_W      = 4;
    localparam int          BSR_W       = FIN_W + FOUT_W;

    // synchroniser
    localparam int          SYNC_STAGES = 2;
    localparam int          PIN_W       = 4;

    typedef enum logic [1:0] {
        JID_SEL_BSR,
        JID_SEL_ID,
        JID_SEL_BYP
    } jid_sel_t;

    typedef struct packed {
        logic trst_n;
        logic tck;
        logic tms;
        logic tdi;
    } jid_pins_t;

    typedef struct packed {
        logic [FOUT_W-1:0] data;
        logic [FOUT_W-1:0] oe_n;
    } jid_fout_t;

endpackage

//--- design/jid_sync.sv
`timescale 1ns/1ps
module jid_sync
    import jid_pkg::*;
(
    input  wire logic      ref_clk,
    input  wire logic      rst,
    input  wire logic      ce,
    input  wire jid_pins_t pin_in,
    output jid_pins_t      pin_q,
    output logic           tck_rise,
    output logic           tck_fall
);
    jid_pins_t meta_r;
    jid_pins_t sync_r;
    logic      tck_prev_r;

    // two stage capture of pins
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            meta_r     <= '0;
            sync_r     <= '0;
            tck_prev_r <= 1'b0;
        end
        else if (ce)
        begin
            meta_r     <= pin_in;
            sync_r     <= meta_r;
            tck_prev_r <= sync_r.tck;
        end
    end

    assign pin_q    = sync_r;
    assign tck_rise = ce & sync_r.tck & ~tck_prev_r;
    assign tck_fall = ce & ~sync_r.tck & tck_prev_r;
endmodule

//--- design/jid_tap_decode.sv
`timescale 1ns/1ps
module jid_tap_decode
    import jid_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              ce,
    input  wire logic              tck,
    input  wire logic              tms,
    input  wire logic              tdi,
    input  wire logic              trst_n,
    input  wire logic [FIN_W-1:0]  func_in,
    input  wire jid_fout_t         core_out,
    output jid_fout_t              pin_out,
    output logic                   tdo,
    output logic                   tdo_oe_n,
    output logic [IR_W-1:0]        ir_cur,
    output logic                   test_mode
);
    typedef enum logic [3:0] {
        ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR,
        ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR,
        ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
    } jid_state_t;

    function automatic jid_sel_t jid_sel(input logic [IR_W-1:0] ir);
        unique case (ir)
            IR_EXTEST, IR_SAMPLE: jid_sel = JID_SEL_BSR;
            IR_IDCODE:            jid_sel = JID_SEL_ID;
            default:              jid_sel = JID_SEL_BYP;
        endcase
    endfunction

    jid_pins_t          pin_in;
    jid_pins_t          pin_q;
    logic               tck_rise;
    logic               tck_fall;
    logic               tap_rst;
    jid_state_t         state_r;
    jid_state_t         state_nxt;
    logic [IR_W-1:0]    ir_sh_r;
    logic [IR_W-1:0]    ir_r;
    logic [ID_W-1:0]    id_sh_r;
    logic               byp_r;
    logic [BSR_W-1:0]   bsr_sh_r;
    logic [BSR_W-1:0]   bsr_upd_r;
    logic [FIN_W-1:0]   func_meta_r;
    logic [FIN_W-1:0]   func_sync_r;
    logic               tdo_r;
    logic               tdo_oe_n_r;
    jid_fout_t          pin_out_r;
    jid_sel_t           sel;

    assign pin_in = {trst_n, tck, tms, tdi};

    jid_sync u_sync (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .ce       (ce),
        .pin_in   (pin_in),
        .pin_q    (pin_q),
        .tck_rise (tck_rise),
        .tck_fall (tck_fall)
    );

    // functional input pins cross into ref_clk before capture
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            func_meta_r <= '0;
            func_sync_r <= '0;
        end
        else if (ce)
        begin
            func_meta_r <= func_in;
            func_sync_r <= func_meta_r;
        end
    end

    assign tap_rst = rst | ~pin_q.trst_n;
    assign sel     = jid_sel(ir_r);

    // tap state sequence
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ST_TLR:    state_nxt = pin_q.tms ? ST_TLR    : ST_RTI;
            ST_RTI:    state_nxt = pin_q.tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: state_nxt = pin_q.tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: state_nxt = pin_q.tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  state_nxt = pin_q.tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: state_nxt = pin_q.tms ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: state_nxt = pin_q.tms ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: state_nxt = pin_q.tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: state_nxt = pin_q.tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: state_nxt = pin_q.tms ? ST_TLR    : ST_CAP_IR;
            ST_CAP_IR: state_nxt = pin_q.tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  state_nxt = pin_q.tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: state_nxt = pin_q.tms ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: state_nxt = pin_q.tms ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: state_nxt = pin_q.tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: state_nxt = pin_q.tms ? ST_SEL_DR : ST_RTI;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (tap_rst)
            state_r <= ST_TLR;
        else if (tck_rise)
            state_r <= state_nxt;
    end

    // instruction shift path
    always_ff @(posedge ref_clk)
    begin
        if (tap_rst)
            ir_sh_r <= IR_CAPTURE;
        else if (tck_rise && state_r == ST_CAP_IR)
            ir_sh_r <= IR_CAPTURE;
        else if (tck_rise && state_r == ST_SH_IR)
            ir_sh_r <= {pin_q.tdi, ir_sh_r[IR_W-1:1]};
    end

    // current instruction, latched on falling tck in update-ir
    always_ff @(posedge ref_clk)
    begin
        if (tap_rst)
            ir_r <= IR_RESET;
        else if (ce && state_r == ST_TLR)
            ir_r <= IR_RESET;
        else if (tck_fall && state_r == ST_UPD_IR)
            ir_r <= ir_sh_r;
    end

    // identification register
    always_ff @(posedge ref_clk)
    begin
        if (tap_rst)
            id_sh_r <= ID_VALUE;
        else if (tck_rise && sel == JID_SEL_ID)
        begin
            if (state_r == ST_CAP_DR)
                id_sh_r <= ID_VALUE;
            else if (state_r == ST_SH_DR)
                id_sh_r <= {pin_q.tdi, id_sh_r[ID_W-1:1]};
        end
    end

    // bypass stage
    always_ff @(posedge ref_clk)
    begin
        if (tap_rst)
            byp_r <= 1'b0;
        else if (tck_rise && sel == JID_SEL_BYP)
        begin
            if (state_r == ST_CAP_DR)
                byp_r <= 1'b0;
            else if (state_r == ST_SH_DR)
                byp_r <= pin_q.tdi;
        end
    end

    // boundary scan capture, shift and hold
    always_ff @(posedge ref_clk)
    begin
        if (tap_rst)
            bsr_sh_r <= '0;
        else if (tck_rise && sel == JID_SEL_BSR)
        begin
            if (state_r == ST_CAP_DR)
                bsr_sh_r <= {pin_out_r.data, func_sync_r};
            else if (state_r == ST_SH_DR)
                bsr_sh_r <= {pin_q.tdi, bsr_sh_r[BSR_W-1:1]};
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (tap_rst)
            bsr_upd_r <= '0;
        else if (tck_fall && state_r == ST_UPD_DR && sel == JID_SEL_BSR)
            bsr_upd_r <= bsr_sh_r;
    end

    // serial output, changes on falling tck
    always_ff @(posedge ref_clk)
    begin
        if (tap_rst)
        begin
            tdo_r      <= 1'b0;
            tdo_oe_n_r <= 1'b1;
        end
        else if (tck_fall)
        begin
            tdo_oe_n_r <= ~(state_r == ST_SH_DR || state_r == ST_SH_IR);
            if (state_r == ST_SH_IR)
                tdo_r <= ir_sh_r[0];
            else
                unique case (sel)
                    JID_SEL_ID:  tdo_r <= id_sh_r[0];
                    JID_SEL_BSR: tdo_r <= bsr_sh_r[0];
                    JID_SEL_BYP: tdo_r <= byp_r;
                    default:     tdo_r <= 1'b0;
                endcase
        end
    end

    // functional outputs: scanned update data reaches them only under extest
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            pin_out_r.data <= '0;
            pin_out_r.oe_n <= '1;
        end
        else if (ce)
        begin
            if (ir_r == IR_HIGHZ)
            begin
                pin_out_r.data <= core_out.data;
                pin_out_r.oe_n <= '1;
            end
            else if (ir_r == IR_EXTEST)
            begin
                pin_out_r.data <= bsr_upd_r[BSR_W-1:FIN_W];
                pin_out_r.oe_n <= '0;
            end
            else
                pin_out_r <= core_out;
        end
    end

    assign pin_out   = pin_out_r;
    assign tdo       = tdo_r;
    assign tdo_oe_n  = tdo_oe_n_r;
    assign ir_cur    = ir_r;
    assign test_mode = (ir_r == IR_EXTEST) | (ir_r == IR_HIGHZ);
endmodule

//--- tb/jid_tap_decode_chk.sv
`timescale 1ns/1ps
module jid_tap_decode_chk
    import jid_pkg::*;
(
    input wire logic            ref_clk,
    input wire logic            rst,
    input wire logic            tck,
    input wire logic            trst_n,
    input wire jid_fout_t       core_out,
    input wire jid_fout_t       pin_out,
    input wire logic            tdo,
    input wire logic            tdo_oe_n,
    input wire logic [IR_W-1:0] ir_cur,
    input wire logic            test_mode
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_func;
        ir_cur != IR_EXTEST && ir_cur != IR_HIGHZ |=> pin_out == $past(core_out);
    endproperty
    a_func: assert property (p_func) else $error("pins left core path");
    property p_hz_oe;
        ir_cur == IR_HIGHZ |=> pin_out.oe_n == 4'hf;
    endproperty
    a_hz_oe: assert property (p_hz_oe) else $error("outputs enabled in high-z");
    property p_hz_data;
        ir_cur == IR_HIGHZ |=> pin_out.data == $past(core_out.data);
    endproperty
    a_hz_data: assert property (p_hz_data) else $error("high-z data wrong");
    property p_ext;
        ir_cur == IR_EXTEST |=> pin_out.oe_n == 4'h0;
    endproperty
    a_ext: assert property (p_ext) else $error("extest not driving");
    property p_mode;
        test_mode == (ir_cur == IR_EXTEST || ir_cur == IR_HIGHZ);
    endproperty
    a_mode: assert property (p_mode) else $error("test mode decode wrong");
    property p_trst;
        $fell(trst_n) |-> ##[1:5] ir_cur == IR_IDCODE;
    endproperty
    a_trst: assert property (p_trst) else $error("test reset missed id");
    property p_ir_fall;
        $changed(ir_cur) |-> !tck;
    endproperty
    a_ir_fall: assert property (p_ir_fall) else $error("instruction changed with tck high");
    property p_tdo;
        $changed(tdo) || $changed(tdo_oe_n) |-> !tck;
    endproperty
    a_tdo: assert property (p_tdo) else $error("serial out moved with tck high");
endmodule

bind jid_tap_decode jid_tap_decode_chk i_chk(.ref_clk(ref_clk), .rst(rst), .tck(tck),
    .trst_n(trst_n), .core_out(core_out), .pin_out(pin_out), .tdo(tdo),
    .tdo_oe_n(tdo_oe_n), .ir_cur(ir_cur), .test_mode(test_mode));

//--- tb/jid_jtag_model.sv
`timescale 1ns/1ps
module jid_jtag_model
(
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    output logic      trst_n,
    input  wire logic tdo,
    input  wire logic tdo_oe_n
);
    // serial output enable seen low at sample time
    int oe_low = 0;
    initial
    begin
        tck = 0;
        tms = 1;
        tdi = 0;
        trst_n = 1;
    end
    // one tck period, 320 ns; tdo read late in the low phase
    task automatic step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #200;
        o = tdo;
        if (!tdo_oe_n)
            oe_low++;
        tck = 1;
        #120;
        tck = 0;
    endtask
    // from idle through a scan and back to idle, lsb first
    task automatic scan(input logic ir, input int n, input logic [31:0] d,
                        output logic [31:0] o);
        logic b;
        o = '0;
        step(1, ~tdi, b);
        if (ir)
            step(1, ~tdi, b);
        step(0, ~tdi, b);
        step(0, ~tdi, b);
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, d[i], b);
            o[i] = b;
        end
        step(1, ~tdi, b);
        step(0, ~tdi, b);
    endtask
    // five tck with tms high reach test-logic-reset, then back to idle
    task automatic to_reset;
        logic b;
        for (int i = 0; i < 5; i++)
            step(1, ~tdi, b);
        step(0, ~tdi, b);
    endtask
    task automatic reset;
        logic b;
        trst_n = 0;
        #400;
        trst_n = 1;
        #200;
        step(0, ~tdi, b);
    endtask
endmodule

//--- tb/jid_tap_decode_test.sv
`timescale 1ns/1ps
module jid_tap_decode_test
    import jid_pkg::*;
;
    logic        ref_clk = 0;
    logic        rst = 1;
    logic [3:0]  func_in = 4'ha;
    jid_fout_t   core_out = 8'h5a;
    jid_fout_t   pin_out;
    logic        tck, tms, tdi, trst_n, tdo, tdo_oe_n, test_mode;
    logic [3:0]  ir_cur;
    logic [31:0] o;
    int          n_errors = 0;
    int          checked = 0;
    int          cyc = 0;

    always #20 ref_clk = ~ref_clk;

    jid_tap_decode i_dut(.ref_clk(ref_clk), .rst(rst), .ce(1'b1), .tck(tck), .tms(tms),
        .tdi(tdi), .trst_n(trst_n), .func_in(func_in), .core_out(core_out),
        .pin_out(pin_out), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .ir_cur(ir_cur),
        .test_mode(test_mode));
    jid_jtag_model i_jtag(.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo),
        .tdo_oe_n(tdo_oe_n));

    task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
        checked++;
        if (s !== e)
        begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", nm, e, s);
        end
    endtask
    task print_verdict;
        $display("errors %0d, checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            n_errors++;
            print_verdict();
        end
    end

    task t_id;
        int k;
        chk("ir", IR_IDCODE, ir_cur);
        chk("tdo oe", 1'b1, tdo_oe_n);
        i_jtag.reset();
        k = i_jtag.oe_low;
        i_jtag.scan(0, 32, 32'h0, o);
        chk("id", ID_VALUE, o);
        chk("oe low bits", 32, i_jtag.oe_low - k);
        chk("pins", core_out, pin_out);
        i_jtag.scan(1, 4, IR_IDCODE, o);
        chk("ir capture", IR_CAPTURE, o);
    endtask
    task t_byp;
        for (int c = 3; c < 16; c++)
        begin
            if (c == 4)
                continue;
            i_jtag.scan(1, 4, c, o);
            chk("ir", c, ir_cur);
            i_jtag.scan(0, 2, 32'h3, o);
            chk("bypass", 32'h2, o);
            chk("pins", core_out, pin_out);
        end
    endtask
    task t_hz;
        i_jtag.scan(1, 4, IR_HIGHZ, o);
        chk("oe", 4'hf, pin_out.oe_n);
        i_jtag.scan(0, 2, 32'h3, o);
        chk("bypass", 32'h2, o);
        chk("oe", 4'hf, pin_out.oe_n);
    endtask
    task t_bsr;
        i_jtag.scan(1, 4, IR_SAMPLE, o);
        i_jtag.scan(0, 8, 32'h3c, o);
        chk("sample", {core_out.data, func_in}, o);
        i_jtag.scan(1, 4, IR_EXTEST, o);
        chk("drive", 8'h30, pin_out);
        i_jtag.reset();
        chk("ir", IR_IDCODE, ir_cur);
        chk("pins", core_out, pin_out);
    endtask
    task t_tlr;
        i_jtag.scan(1, 4, IR_BYPASS, o);
        chk("ir", IR_BYPASS, ir_cur);
        i_jtag.to_reset();
        chk("ir", IR_IDCODE, ir_cur);
        i_jtag.scan(0, 32, 32'h0, o);
        chk("id", ID_VALUE, o);
        chk("pins", core_out, pin_out);
        chk("tdo oe", 1'b1, tdo_oe_n);
    endtask

    initial
    begin
        repeat (3) @(negedge ref_clk);
        rst = 0;
        repeat (4) @(negedge ref_clk);
        t_id();
        t_byp();
        t_hz();
        t_bsr();
        t_tlr();
        print_verdict();
    end
endmodule
